// File: hw/scpb_consts.svh
/*
 * Constants of the system control port: address, field positions and reset value.
 * Assumes inclusion by bare name from the package and the port module.
 */
`ifndef SCPB_CONSTS_SVH
`define SCPB_CONSTS_SVH

`define SCPB_IO_ADDR_W        16
`define SCPB_PORT_ADDR        16'h0061
`define SCPB_PORT_RESET       8'h20
`define SCPB_RW_MASK          8'h0f
`define SCPB_BIT_GATE         0
`define SCPB_BIT_SPKR_DATA    1
`define SCPB_BIT_PARITY_DIS   2
`define SCPB_BIT_CHCK_DIS     3
`define SCPB_BIT_REFRESH      4
`define SCPB_BIT_TIMER2       5
`define SCPB_BIT_CHCK         6
`define SCPB_BIT_PARITY_ERR   7
`define SCPB_REFRESH_US       15
`define SCPB_CLK_MHZ          250
`define SCPB_REFRESH_CYCLES   (`SCPB_REFRESH_US * `SCPB_CLK_MHZ)

`endif

// File: hw/scpb_pkg.sv
/*
 * Types of the system control port.
 * Assumes the constants header is on the include path.
 */
`include "scpb_consts.svh"

package scpb_pkg;

   // One CPU I/O request; rd and wr are one-cycle strobes.
   typedef struct packed {
      logic [`SCPB_IO_ADDR_W-1:0] addr;
      logic                       rd;
      logic                       wr;
      logic [7:0]                 wdata;
   } scpb_io_req_t;

   // Software-written control bits, bits 0 to 3 of the port.
   typedef struct packed {
      logic chck_dis;
      logic parity_dis;
      logic spkr_data;
      logic gate;
   } scpb_ctrl_t;

endpackage

// File: hw/scpb_port.sv
/*
 * System control port at I/O address 61h: timer 2 gate, speaker output,
 * refresh toggle, timer 2 readback and the parity and channel-check latches.
 * Assumes the I/O request, timer outputs, refresh pulse and parity error
 * come from logic on i_core_clk; the channel-check line is an external pin.
 */
`timescale 1ns/100ps

`include "scpb_consts.svh"

// How it works
// - Decode I/O address 61h for reads, writes.
// - Bits 0-3 read/write; bits 4-7 ignore writes.
// - Without local latches, bits 6,7 read zero.
// - Port holds 20h after hardware reset.
// - Bit 0 gates timer 2 count clock.
// - Gate low forces bit 5 to one.
// - Speaker is NAND of bit 1, bit 5.
// - Bit 2 set presets parity latch, disables checking.
// - Parity error sets latch; active-low fault output.
// - Block input stops parity latch from setting.
// - Bit 3 set clears channel-check latch unless pin low, disables NMI.
// - Channel-check pin sets latch; bit 6, NMI.
// - Bit 4 toggles on every refresh pulse while clock enable is high.
// - Bit 5 shows timer 2 output level.
// - Bit 7 reads one after a parity error.
module scpb_port
   import scpb_pkg::*;
#(
   parameter bit LOCAL_LATCHES = 1'b1  // Latch status shown in bits 6 and 7 of the port.
) (
   input  wire logic         i_core_clk,             // Core clock, 250 MHz.
   input  wire logic         i_arst_n,               // Asynchronous reset, active low.
   input  wire logic         i_clk_en,               // Clock enable; freezes all state when low.
   input  wire scpb_io_req_t i_io_req,               // CPU I/O request.
   input  wire logic         i_timer2_out,           // Timer channel 2 output level.
   input  wire logic         i_refresh_pulse,        // Refresh request pulse from timer 1.
   input  wire logic         i_parity_error,         // Local memory parity error pulse.
   input  wire logic         i_parity_block,         // Blocks parity errors from the latch.
   input  wire logic         i_chan_check_n,         // Bus channel-check pin, active low.
   output logic [7:0]        o_io_rdata,             // Read data.
   output logic              o_io_rdata_en,          // Read data valid, one cycle.
   output logic              o_tone_timer_gate,      // Gate to timer channel 2.
   output logic              o_speaker,              // Speaker signal.
   output logic              o_memory_parity_fault_n,// Parity latch to NMI logic, active low.
   output logic              o_chan_check_nmi_n      // Channel-check latch to NMI logic, active low.
);

   // Pin synchroniser for the channel-check line.
   logic       chk_meta_n;
   logic       chk_sync_n;
   logic       next_chk_meta_n;
   logic       next_chk_sync_n;

   // Reset image of the whole port; only the writable low nibble is stored,
   // the upper bits come back from live status when the port is read.
   localparam logic [7:0] PORT_RESET = `SCPB_PORT_RESET;

   // Registered state and next values.
   scpb_ctrl_t ctrl;
   scpb_ctrl_t next_ctrl;
   logic       refresh_tgl;
   logic       next_refresh_tgl;
   logic       parity_err;
   logic       next_parity_err;
   logic       chck_q;
   logic       next_chck_q;
   logic       chck_nmi_n;
   logic       next_chck_nmi_n;
   logic [7:0] rdata;
   logic [7:0] next_rdata;
   logic       rdata_en;
   logic       next_rdata_en;
   logic       speaker;
   logic       next_speaker;
   logic       parity_fault_n;
   logic       next_parity_fault_n;

   // Combinational helpers.
   logic       hit;
   logic       timer2_seen;
   logic [7:0] port_value;
   logic [7:0] wr_bits;

   // Pin synchroniser: only the second stage is read by the latch logic,
   // so a metastable first stage never reaches the status bits or NMI.
   // Both stages start at the idle level of the pin, so reset gives no
   // false channel-check event.
   always_comb begin
      next_chk_meta_n = i_chan_check_n;
      next_chk_sync_n = chk_meta_n;
   end

   always_ff @(posedge i_core_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         chk_meta_n <= 1'b1;
         chk_sync_n <= 1'b1;
      end else if (i_clk_en) begin
         chk_meta_n <= next_chk_meta_n;
         chk_sync_n <= next_chk_sync_n;
      end
   end

   // Address decode and the status bits as software sees them.
   // The full address is compared, so no alias of the port answers.
   always_comb begin
      hit         = (i_io_req.addr == `SCPB_PORT_ADDR);
      timer2_seen = ctrl.gate ? i_timer2_out : 1'b1;
      port_value  = 8'h00;
      port_value[`SCPB_BIT_GATE]       = ctrl.gate;
      port_value[`SCPB_BIT_SPKR_DATA]  = ctrl.spkr_data;
      port_value[`SCPB_BIT_PARITY_DIS] = ctrl.parity_dis;
      port_value[`SCPB_BIT_CHCK_DIS]   = ctrl.chck_dis;
      port_value[`SCPB_BIT_REFRESH]    = refresh_tgl;
      port_value[`SCPB_BIT_TIMER2]     = timer2_seen;
      if (LOCAL_LATCHES) begin
         port_value[`SCPB_BIT_CHCK]       = chck_q;
         port_value[`SCPB_BIT_PARITY_ERR] = parity_err;
      end
   end

   // Control bits and the bus answer.
   always_comb begin
      next_ctrl     = ctrl;
      next_rdata    = rdata;
      next_rdata_en = 1'b0;
      wr_bits       = i_io_req.wdata & `SCPB_RW_MASK;
      // The read-only upper nibble is dropped here; a write never reaches it.
      if (hit && i_io_req.wr) begin
         next_ctrl = wr_bits[3:0];
      end
      // A read in the same cycle as a write returns the value before the write.
      if (hit && i_io_req.rd) begin
         next_rdata    = port_value;
         next_rdata_en = 1'b1;
      end
   end

   always_ff @(posedge i_core_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         ctrl     <= PORT_RESET[3:0];
         rdata    <= 8'h00;
         rdata_en <= 1'b0;
      end else if (i_clk_en) begin
         ctrl     <= next_ctrl;
         rdata    <= next_rdata;
         rdata_en <= next_rdata_en;
      end
   end

   // Refresh toggle and speaker.
   // The toggle follows every refresh pulse taken with the clock enable high, whether or not bus refresh runs,
   // because software uses it as a coarse time base.
   // The speaker is registered so that the pin never glitches when the timer
   // output and the data bit change in the same cycle.
   always_comb begin
      next_refresh_tgl = refresh_tgl ^ i_refresh_pulse;
      next_speaker     = ~(ctrl.spkr_data & timer2_seen);
   end

   always_ff @(posedge i_core_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         refresh_tgl <= 1'b0;
         speaker     <= 1'b1;
      end else if (i_clk_en) begin
         refresh_tgl <= next_refresh_tgl;
         speaker     <= next_speaker;
      end
   end

   // Parity latch: the disable bit acts as a preset that overrides any error.
   // Channel-check latch: the pin sets it and wins over the disable bit on Q,
   // while on the NMI side the disable bit wins over the pin, as a preset/clear flop.
   always_comb begin
      next_parity_err = parity_err;
      if (ctrl.parity_dis) begin
         next_parity_err = 1'b0;
      end else if (i_parity_error && !i_parity_block) begin
         next_parity_err = 1'b1;
      end
      next_chck_q = chck_q;
      if (!chk_sync_n) begin
         next_chck_q = 1'b1;
      end else if (ctrl.chck_dis) begin
         next_chck_q = 1'b0;
      end
      next_chck_nmi_n = ctrl.chck_dis | ~next_chck_q;
      // The NMI side of the parity latch is its own flop, so the pin carries
      // no logic after the register and cannot glitch.
      next_parity_fault_n = ~next_parity_err;
   end

   always_ff @(posedge i_core_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         parity_err     <= 1'b0;
         parity_fault_n <= 1'b1;
         chck_q         <= 1'b0;
         chck_nmi_n     <= 1'b1;
      end else if (i_clk_en) begin
         parity_err     <= next_parity_err;
         parity_fault_n <= next_parity_fault_n;
         chck_q         <= next_chck_q;
         chck_nmi_n     <= next_chck_nmi_n;
      end
   end

   // Every output below is a register; this process only renames them.
   // The timer gate leaves the block as the stored bit itself, so the
   // external timer sees the new gate one cycle after the write is taken.

   always_comb begin
      o_io_rdata              = rdata;
      o_io_rdata_en           = rdata_en;
      o_tone_timer_gate       = ctrl.gate;
      o_speaker               = speaker;
      o_memory_parity_fault_n = parity_fault_n;
      o_chan_check_nmi_n      = chck_nmi_n;
   end

endmodule // scpb_port

// File: verification/scpb_chk.sv
/* Checker of the system control port outputs.
   Assumes it is bound to scpb_port and sees only its ports. */
`timescale 1ns/100ps
`include "scpb_consts.svh"
module scpb_chk
   import scpb_pkg::*;
#(
   parameter bit LOCAL_LATCHES = 1'b1
) (
   input wire logic         i_core_clk,              // Clock.
   input wire logic         i_arst_n,                // Reset.
   input wire logic         i_clk_en,                // Enable.
   input wire scpb_io_req_t i_io_req,                // Request.
   input wire logic         i_timer2_out,            // Timer 2.
   input wire logic         i_refresh_pulse,         // Refresh.
   input wire logic         i_parity_error,          // Parity error.
   input wire logic         i_parity_block,          // Parity block.
   input wire logic         i_chan_check_n,          // Check pin.
   input wire logic [7:0]   o_io_rdata,              // Read data.
   input wire logic         o_io_rdata_en,           // Read valid.
   input wire logic         o_tone_timer_gate,       // Gate.
   input wire logic         o_speaker,               // Speaker.
   input wire logic         o_memory_parity_fault_n, // Parity fault.
   input wire logic         o_chan_check_nmi_n       // Check fault.
);
   logic hit;
   assign hit = i_clk_en && i_io_req.addr == `SCPB_PORT_ADDR;
   default clocking @(posedge i_core_clk); endclocking
   default disable iff (!i_arst_n);
   rd_answer_a:
      assert property (hit && i_io_req.rd |=> o_io_rdata_en)
      else $error("read not answered");
   no_answer_a:
      assert property (i_clk_en && !(hit && i_io_req.rd) |=> !o_io_rdata_en)
      else $error("stray read answer");
   gate_write_a:
      assert property (hit && i_io_req.wr |=> o_tone_timer_gate == $past(i_io_req.wdata[0]))
      else $error("gate not written");
   gate_read_a:
      assert property (o_io_rdata_en |-> o_io_rdata[0] == $past(o_tone_timer_gate))
      else $error("gate readback wrong");
   timer_view_a:
      assert property (o_io_rdata_en && $past(i_clk_en) |->
         o_io_rdata[5] == ($past(o_tone_timer_gate) ? $past(i_timer2_out) : 1'b1))
      else $error("timer bit wrong");
   speaker_low_a:
      assert property (!o_speaker && $past(i_clk_en) |->
         !$past(o_tone_timer_gate) || $past(i_timer2_out))
      else $error("speaker low without cause");
   parity_set_a:
      assert property ($fell(o_memory_parity_fault_n) |->
         $past(i_parity_error) && !$past(i_parity_block))
      else $error("parity fault without error");
   chck_set_a:
      assert property ($fell(o_chan_check_nmi_n) |->
         !$past(i_chan_check_n, 2) || !$past(i_chan_check_n, 3) || !$past(i_chan_check_n, 4))
      else $error("check fault without pin");
   fault_read_a:
      assert property (o_io_rdata_en && $past(i_clk_en) && LOCAL_LATCHES |->
         o_io_rdata[7] == !$past(o_memory_parity_fault_n))
      else $error("parity bit wrong");
endmodule // scpb_chk
bind scpb_port scpb_chk #(.LOCAL_LATCHES(LOCAL_LATCHES)) scpb_chk_inst (.i_core_clk(i_core_clk),
   .i_arst_n(i_arst_n), .i_clk_en(i_clk_en), .i_io_req(i_io_req), .i_timer2_out(i_timer2_out),
   .i_refresh_pulse(i_refresh_pulse), .i_parity_error(i_parity_error), .i_parity_block(i_parity_block),
   .i_chan_check_n(i_chan_check_n), .o_io_rdata(o_io_rdata), .o_io_rdata_en(o_io_rdata_en),
   .o_tone_timer_gate(o_tone_timer_gate), .o_speaker(o_speaker),
   .o_memory_parity_fault_n(o_memory_parity_fault_n), .o_chan_check_nmi_n(o_chan_check_nmi_n));

// File: verification/tb_system_control_port_b.sv
/* Bench of the system control port.
   Assumes the design and checker are compiled first. */
`timescale 1ns/100ps
module tb_system_control_port_b
   import scpb_pkg::*;
;
   logic clk = 0, rst_n = 0, en = 1, t2 = 0, rfp = 0, perr = 0, pblk = 0, pin_n = 1;
   scpb_io_req_t req = '0;
   logic [7:0] rdata, rdata2;
   logic rden, gate, spk, pf_n, cn_n;
   int n_mismatch = 0, n_compared = 0, cyc = 0;
   always #2 clk = ~clk;
   scpb_port scpb_port_inst (.i_core_clk(clk), .i_arst_n(rst_n), .i_clk_en(en), .i_io_req(req),
      .i_timer2_out(t2), .i_refresh_pulse(rfp), .i_parity_error(perr), .i_parity_block(pblk),
      .i_chan_check_n(pin_n), .o_io_rdata(rdata), .o_io_rdata_en(rden), .o_tone_timer_gate(gate),
      .o_speaker(spk), .o_memory_parity_fault_n(pf_n), .o_chan_check_nmi_n(cn_n));
   // Second copy without the latch status bits in the port.
   scpb_port #(.LOCAL_LATCHES(1'b0)) scpb_port_inst_b (.i_core_clk(clk), .i_arst_n(rst_n), .i_clk_en(en),
      .i_io_req(req), .i_timer2_out(t2), .i_refresh_pulse(rfp), .i_parity_error(perr),
      .i_parity_block(pblk), .i_chan_check_n(pin_n), .o_io_rdata(rdata2), .o_io_rdata_en(),
      .o_tone_timer_gate(), .o_speaker(), .o_memory_parity_fault_n(), .o_chan_check_nmi_n());
   task wrap_up;
      if (n_mismatch == 0 && n_compared > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   task chk(input logic [7:0] seen, input logic [7:0] exp);
      n_compared++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("ERROR %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task io(input logic [15:0] a, input logic r, input logic w, input logic [7:0] d);
      @(negedge clk);
      req = '{a, r, w, d};
      @(negedge clk);
      req = '0;
   endtask
   task rd(input logic [15:0] a, input logic [7:0] exp);
      io(a, 1'b1, 1'b0, 8'h00);
      chk({7'h00, rden}, {7'h00, a == 16'h0061});
      if (rden === 1'b1)
         chk(rdata, exp);
   endtask
   task wr(input logic [7:0] d);
      io(16'h0061, 1'b0, 1'b1, d);
   endtask
   always @(posedge clk) begin
      cyc++;
      if (cyc == 3000) begin
         n_mismatch++;
         wrap_up;
      end
   end
   initial begin
      repeat (20) @(negedge clk);
      rst_n = 1;
      rd(16'h0061, 8'h20);
      chk({4'h0, gate, spk, pf_n, cn_n}, 8'h07);
      rd(16'h0062, 8'h00);
      wr(8'hff);
      rd(16'h0061, 8'h0f);
      chk({7'h00, gate}, 8'h01);
      t2 = 1;
      repeat (2) @(negedge clk);
      chk({7'h00, spk}, 8'h00);
      rd(16'h0061, 8'h2f);
      t2 = 0;
      wr(8'h02);
      rd(16'h0061, 8'h22);
      chk({7'h00, spk}, 8'h00);
      wr(8'h00);
      rfp = 1;
      @(negedge clk);
      rfp = 0;
      rd(16'h0061, 8'h30);
      chk({7'h00, spk}, 8'h01);
      rfp = 1;
      @(negedge clk);
      rfp = 0;
      rd(16'h0061, 8'h20);
      en = 0;
      rfp = 1;
      @(negedge clk);
      rfp = 0;
      en = 1;
      rd(16'h0061, 8'h20);
      perr = 1;
      @(negedge clk);
      perr = 0;
      rd(16'h0061, 8'ha0);
      chk(rdata2, 8'h20);
      chk({7'h00, pf_n}, 8'h00);
      wr(8'h04);
      perr = 1;
      @(negedge clk);
      perr = 0;
      rd(16'h0061, 8'h24);
      chk({7'h00, pf_n}, 8'h01);
      wr(8'h00);
      pblk = 1;
      perr = 1;
      @(negedge clk);
      perr = 0;
      rd(16'h0061, 8'h20);
      pblk = 0;
      pin_n = 0;
      repeat (5) @(negedge clk);
      pin_n = 1;
      rd(16'h0061, 8'h60);
      chk(rdata2, 8'h20);
      chk({7'h00, cn_n}, 8'h00);
      wr(8'h08);
      rd(16'h0061, 8'h28);
      chk({7'h00, cn_n}, 8'h01);
      perr = 1;
      @(negedge clk);
      perr = 0;
      chk({7'h00, pf_n}, 8'h00);
      rst_n = 0;
      @(negedge clk);
      rst_n = 1;
      chk({6'h00, pf_n, cn_n}, 8'h03);
      rd(16'h0061, 8'h20);
      wrap_up;
   end
endmodule // tb_system_control_port_b
